// [cfe_detect.sv]
// Field length and vertical event detection for capture channel A
`timescale 1ns/1ps
`default_nettype none
module cfe_detect #(
  parameter int LCW = 12
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Settings
  input  wire cfe_pkg::cfe_mode_t mode,
  input  wire logic             long_en,
  input  wire logic             short_en,
  input  wire logic             reset_select,
  input  wire logic [LCW-1:0]   last_line_setting,
  // Channel timing
  input  wire logic [LCW-1:0]   line_counter,
  input  wire logic             line_counter_reset,
  input  wire logic             field_is_2,
  input  wire logic             vert_event,
  // Event pulses
  output logic                  long_ev,
  output logic                  short_ev,
  output logic                  vert1_ev,
  output logic                  vert2_ev
);
  import cfe_pkg::*;

  logic armed_q, armed_d;
  logic long_d, short_d, v1_d, v2_d;
  logic [LCW-1:0] over_line;
  logic std;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Armed once per field so a stalled counter gives one long event only
  always_comb begin
    std       = cfe_is_std(mode);
    over_line = LCW'(last_line_setting + 1'b1);
    armed_d   = armed_q;
    long_d    = 1'b0;
    short_d   = 1'b0;
    if (line_counter_reset) begin
      armed_d = 1'b1;
      short_d = std && short_en && (line_counter < last_line_setting); // RULE3 RULE6
      long_d  = std && long_en && reset_select; // RULE2 RULE6
    end else if (armed_q && line_counter == over_line) begin
      armed_d = 1'b0;
      long_d  = std && long_en && !reset_select; // RULE1 RULE2 RULE6
    end
    v1_d = vert_event && !field_is_2 && cfe_vert_ok(mode); // RULE5 RULE7
    v2_d = vert_event && field_is_2 && cfe_vert_ok(mode); // RULE4 RULE7
  end

  // Registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_q  <= 1'b1;
      long_ev  <= 1'b0;
      short_ev <= 1'b0;
      vert1_ev <= 1'b0;
      vert2_ev <= 1'b0;
    end else begin
      armed_q  <= armed_d;
      long_ev  <= long_d;
      short_ev <= short_d;
      vert1_ev <= v1_d;
      vert2_ev <= v2_d;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  short_field_a: assert property (@(posedge clk) disable iff (rst) // RULE3
    line_counter_reset && cfe_is_std(mode) && short_en && line_counter < last_line_setting
    |=> short_ev)
    else $error("short field not reported");
  field_unused_a: assert property (@(posedge clk) disable iff (rst) // RULE6
    !cfe_is_std($past(mode)) |-> !long_ev && !short_ev)
    else $error("field flag event outside standard capture");
  vert_unused_a: assert property (@(posedge clk) disable iff (rst) // RULE7
    ($past(mode) == CFE_RAW || $past(mode) == CFE_STREAM) |-> !vert1_ev && !vert2_ev)
    else $error("vertical event in raw or stream mode");
  always_long_a: assert property (@(posedge clk) disable iff (rst) // RULE2
    line_counter_reset && cfe_is_std(mode) && long_en && reset_select |=> long_ev)
    else $error("reset select set but long field not reported");
endmodule : cfe_detect
`default_nettype wire

// [cfe_params.svh]
// Constants for the capture channel A field event flag block
// How it works
// [RULE1] Standard capture modes: flag a long field when counter reaches last line plus one.
// [RULE2] Long detection only with reset select 0; with select 1 every field is long.
// [RULE3] Standard capture modes: flag a short field when counter resets before last line.
// [RULE4] Field 2 vertical event sets its flag in standard capture or display modes.
// [RULE5] Field 1 vertical event sets its flag in standard capture or display modes.
// [RULE6] Long and short flags never set in raw, transport stream or display modes.
// [RULE7] Vertical flags never set in raw or transport stream capture modes.
// [RULE8] Flags reset to 0, read 1 after event, cleared by writing 1.
// [RULE9] Flags stay set until software clears them, whatever the cause does.
`ifndef CFE_PARAMS_SVH
`define CFE_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CFE_STATUS_OFS   12'h000
`define CFE_MASK_OFS     12'h004
`define CFE_CTRL_OFS     12'h008
`define CFE_LAST_OFS     12'h00C

// ----------------------------------------------------------------------
// Status and mask field positions
// ----------------------------------------------------------------------
`define CFE_VERT1_BIT    4
`define CFE_VERT2_BIT    5
`define CFE_SHORT_BIT    6
`define CFE_LONG_BIT     7
`define CFE_FLAG_LSB     4
`define CFE_FLAG_MSB     7

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CFE_MODE_LSB     0
`define CFE_MODE_MSB     2
`define CFE_LONG_EN_BIT  4
`define CFE_SHORT_EN_BIT 5
`define CFE_VRSEL_BIT    8

// Mode field encodings
`define CFE_MODE_BT656   3'h0
`define CFE_MODE_YC      3'h1
`define CFE_MODE_RAW     3'h2
`define CFE_MODE_STREAM  3'h3
`define CFE_MODE_DISP    3'h4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define CFE_FLAGS_RST    4'h0
`define CFE_MASK_RST     4'h0
`define CFE_CTRL_RST     32'h0000_0002
`define CFE_LAST_RST     32'h0000_0000

`endif

// [cfe_pkg.sv]
// Types and shared decode functions for the field event flag block
`include "cfe_params.svh"
package cfe_pkg;

  // Channel operating mode
  typedef enum logic [2:0] {
    CFE_BT656,
    CFE_YC,
    CFE_RAW,
    CFE_STREAM,
    CFE_DISP
  } cfe_mode_t;

  // Unknown codes fall to raw so no flag fires on a bad setting
  function automatic cfe_mode_t cfe_decode_mode(input logic [2:0] code);
    case (code)
      `CFE_MODE_BT656: cfe_decode_mode = CFE_BT656;
      `CFE_MODE_YC:    cfe_decode_mode = CFE_YC;
      `CFE_MODE_STREAM: cfe_decode_mode = CFE_STREAM;
      `CFE_MODE_DISP:  cfe_decode_mode = CFE_DISP;
      default:         cfe_decode_mode = CFE_RAW;
    endcase
  endfunction : cfe_decode_mode

  // Standard video capture modes
  function automatic logic cfe_is_std(input cfe_mode_t m);
    cfe_is_std = (m == CFE_BT656) || (m == CFE_YC);
  endfunction : cfe_is_std

  // Modes where vertical events are reported
  function automatic logic cfe_vert_ok(input cfe_mode_t m);
    cfe_vert_ok = cfe_is_std(m) || (m == CFE_DISP);
  endfunction : cfe_vert_ok

endpackage : cfe_pkg

// [cfe_top.sv]
// APB register slave with sticky field event flags and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "cfe_params.svh"
module cfe_top #(
  parameter int LCW = 12
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Capture channel timing
  input  wire logic [LCW-1:0]   line_counter,
  input  wire logic             line_counter_reset,
  input  wire logic             field_is_2,
  input  wire logic             vert_event,
  // Interrupt
  output logic                  irq
);
  import cfe_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [3:0]     status_q, status_d;
  logic [3:0]     mask_q, mask_d;
  logic [31:0]    ctrl_q, ctrl_d;
  logic [31:0]    last_q, last_d;
  logic [31:0]    prdata_d;
  logic           pready_d;
  logic           pslverr_d;
  logic           irq_d;
  logic           access;
  logic           wr_stb;
  logic           rd_stb;
  logic           hit;
  logic [3:0]     events;
  logic [3:0]     w1c;
  logic           long_ev;
  logic           short_ev;
  logic           vert1_ev;
  logic           vert2_ev;
  cfe_mode_t      mode;

  // ----------------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------------
  // Word aligned decode only; low address bits are ignored
  function automatic logic cfe_mapped(input logic [11:0] a);
    logic [11:0] w;
    w = {a[11:2], 2'b00};
    cfe_mapped = (w == `CFE_STATUS_OFS) || (w == `CFE_MASK_OFS) ||
                 (w == `CFE_CTRL_OFS) || (w == `CFE_LAST_OFS);
  endfunction : cfe_mapped

  function automatic logic cfe_is(input logic [11:0] a, input logic [11:0] ofs);
    cfe_is = ({a[11:2], 2'b00} == ofs);
  endfunction : cfe_is

  // Place the four flag bits at their status positions
  function automatic logic [31:0] cfe_flags_word(input logic [3:0] f);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[`CFE_FLAG_MSB:`CFE_FLAG_LSB] = f;
    cfe_flags_word = v;
  endfunction : cfe_flags_word

  // Read mux; reserved bits read as zero
  function automatic logic [31:0] cfe_read(input logic [11:0] a,
                                           input logic [3:0]  st,
                                           input logic [3:0]  mk,
                                           input logic [31:0] ct,
                                           input logic [31:0] ll);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (cfe_is(a, `CFE_STATUS_OFS)) begin
      v = cfe_flags_word(st);
    end else if (cfe_is(a, `CFE_MASK_OFS)) begin
      v = cfe_flags_word(mk);
    end else if (cfe_is(a, `CFE_CTRL_OFS)) begin
      v = ct;
    end else if (cfe_is(a, `CFE_LAST_OFS)) begin
      v = ll;
    end
    cfe_read = v;
  endfunction : cfe_read

  // ----------------------------------------------------------------------
  // Detection
  // ----------------------------------------------------------------------
  // Mode taken from the live control word so a mode change acts next cycle
  assign mode = cfe_decode_mode(ctrl_q[`CFE_MODE_MSB:`CFE_MODE_LSB]);

  cfe_detect #(
    .LCW (LCW)
  ) u_detect (
    .clk                (clk),
    .rst                (rst),
    .mode               (mode),
    .long_en            (ctrl_q[`CFE_LONG_EN_BIT]),
    .short_en           (ctrl_q[`CFE_SHORT_EN_BIT]),
    .reset_select       (ctrl_q[`CFE_VRSEL_BIT]),
    .last_line_setting  (last_q[LCW-1:0]),
    .line_counter       (line_counter),
    .line_counter_reset (line_counter_reset),
    .field_is_2         (field_is_2),
    .vert_event         (vert_event),
    .long_ev            (long_ev),
    .short_ev           (short_ev),
    .vert1_ev           (vert1_ev),
    .vert2_ev           (vert2_ev)
  );

  // Event vector in status bit order, bit 0 is status bit 4
  assign events = {long_ev, short_ev, vert2_ev, vert1_ev};

  // ----------------------------------------------------------------------
  // Bus phase decode
  // ----------------------------------------------------------------------
  // One wait state: pready rises on the second access cycle, which keeps
  // the read mux off the setup-phase address path
  always_comb begin
    access = psel && penable;
    wr_stb = access && pready && pwrite;
    rd_stb = access && !pready && !pwrite;
    hit    = cfe_mapped(paddr);
  end

  // ----------------------------------------------------------------------
  // Register next state
  // ----------------------------------------------------------------------
  // Event set wins over a same-cycle write-one clear
  always_comb begin
    status_d = status_q;
    mask_d   = mask_q;
    ctrl_d   = ctrl_q;
    last_d   = last_q;
    w1c      = 4'h0;
    if (wr_stb && cfe_is(paddr, `CFE_STATUS_OFS)) begin
      w1c = pwdata[`CFE_FLAG_MSB:`CFE_FLAG_LSB]; // RULE8
    end
    if (wr_stb && cfe_is(paddr, `CFE_MASK_OFS)) begin
      mask_d = pwdata[`CFE_FLAG_MSB:`CFE_FLAG_LSB];
    end
    if (wr_stb && cfe_is(paddr, `CFE_CTRL_OFS)) begin
      ctrl_d = 32'h0000_0000;
      ctrl_d[`CFE_MODE_MSB:`CFE_MODE_LSB] = pwdata[`CFE_MODE_MSB:`CFE_MODE_LSB];
      ctrl_d[`CFE_LONG_EN_BIT]  = pwdata[`CFE_LONG_EN_BIT];
      ctrl_d[`CFE_SHORT_EN_BIT] = pwdata[`CFE_SHORT_EN_BIT];
      ctrl_d[`CFE_VRSEL_BIT]    = pwdata[`CFE_VRSEL_BIT];
    end
    if (wr_stb && cfe_is(paddr, `CFE_LAST_OFS)) begin
      last_d = 32'h0000_0000;
      last_d[LCW-1:0] = pwdata[LCW-1:0];
    end
    status_d = (status_q & ~w1c) | events; // RULE8 RULE9
  end

  // Register storage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q <= `CFE_FLAGS_RST; // RULE8
      mask_q   <= `CFE_MASK_RST;
      ctrl_q   <= `CFE_CTRL_RST;
      last_q   <= `CFE_LAST_RST;
    end else begin
      status_q <= status_d;
      mask_q   <= mask_d;
      ctrl_q   <= ctrl_d;
      last_q   <= last_d;
    end
  end

  // ----------------------------------------------------------------------
  // Bus answer and interrupt
  // ----------------------------------------------------------------------
  // Unmapped addresses answer with pslverr and zero data
  always_comb begin
    pready_d  = access && !pready;
    pslverr_d = access && !pready && !hit;
    prdata_d  = 32'h0000_0000;
    if (rd_stb) begin
      prdata_d = cfe_read(paddr, status_q, mask_q, ctrl_q, last_q);
    end
    irq_d = |(status_d & mask_d);
  end

  // Outputs straight from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      irq     <= 1'b0;
    end else begin
      pready  <= pready_d;
      pslverr <= pslverr_d;
      prdata  <= prdata_d;
      irq     <= irq_d;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Flag set in the same cycle as a clear must still read set
  set_wins_a: assert property (@(posedge clk) disable iff (rst) // RULE8
    (events[3] && w1c[3]) |=> status_q[3])
    else $error("long flag lost on clear collision");

  // Flag stays set until a one is written to it
  flag_sticky_a: assert property (@(posedge clk) disable iff (rst) // RULE9
    (status_q[0] && !w1c[0]) |=> status_q[0])
    else $error("field 1 flag dropped without clear");

  // Write one clears a flag when no new event arrives
  write_clear_a: assert property (@(posedge clk) disable iff (rst) // RULE8
    (wr_stb && cfe_is(paddr, `CFE_STATUS_OFS) && pwdata[`CFE_SHORT_BIT] && !events[2])
    |=> !status_q[2])
    else $error("short flag not cleared by write one");

  // Writing zero leaves flags alone
  write_zero_a: assert property (@(posedge clk) disable iff (rst) // RULE8
    (wr_stb && cfe_is(paddr, `CFE_STATUS_OFS) && !pwdata[`CFE_VERT2_BIT] && status_q[1])
    |=> status_q[1])
    else $error("field 2 flag cleared by zero write");

  // Vertical field 2 event reaches its flag two cycles on
  vert2_flag_a: assert property (@(posedge clk) disable iff (rst) // RULE4
    (vert_event && field_is_2 && cfe_vert_ok(mode)) |-> ##2 status_q[1])
    else $error("field 2 vertical event missed");

  // Vertical field 1 event reaches its flag two cycles on
  vert1_flag_a: assert property (@(posedge clk) disable iff (rst) // RULE5
    (vert_event && !field_is_2 && cfe_vert_ok(mode)) |-> ##2 status_q[0])
    else $error("field 1 vertical event missed");

  // Long field past the last line is flagged
  long_flag_a: assert property (@(posedge clk) disable iff (rst) // RULE1
    long_ev |=> status_q[3])
    else $error("long field event not latched");

  // Interrupt follows the masked flags
  irq_level_a: assert property (@(posedge clk) disable iff (rst)
    irq == |(status_q & mask_q))
    else $error("interrupt level mismatch");

  // Every access is answered within two cycles
  bus_answer_a: assert property (@(posedge clk) disable iff (rst)
    (psel && !penable) ##1 (psel && penable) |-> ##[0:1] pready)
    else $error("bus access not answered");

  // Short field event is latched into its flag
  short_flag_a: assert property (@(posedge clk) disable iff (rst) // RULE3
    short_ev |=> status_q[2])
    else $error("short field event not latched");

  // Any flag set in the same cycle as its clear must still read set
  set_wins_all_a: assert property (@(posedge clk) disable iff (rst) // RULE8
    (|(events & w1c)) |=> ((status_q & $past(events & w1c)) == $past(events & w1c)))
    else $error("flag lost on clear collision");

  // No flag drops unless a one was written to it
  sticky_all_a: assert property (@(posedge clk) disable iff (rst) // RULE9
    (status_q & $past(status_q & ~w1c)) == $past(status_q & ~w1c))
    else $error("flag dropped without clear");

  // Write one clears the long flag when no new event arrives
  clear_long_a: assert property (@(posedge clk) disable iff (rst) // RULE8
    (wr_stb && cfe_is(paddr, `CFE_STATUS_OFS) && pwdata[`CFE_LONG_BIT] && !events[3])
    |=> !status_q[3])
    else $error("long flag not cleared by write one");

  // Error response only comes with the ready pulse
  slverr_pair_a: assert property (@(posedge clk) disable iff (rst)
    pslverr |-> pready)
    else $error("error response without ready");

  // Ready is a single-cycle pulse
  ready_pulse_a: assert property (@(posedge clk) disable iff (rst)
    pready |=> !pready)
    else $error("ready held for more than one cycle");

  // Read data stays zero outside the ready cycle
  rdata_idle_a: assert property (@(posedge clk) disable iff (rst)
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data driven outside ready cycle");

  // A write to an unmapped address leaves the settings alone
  unmapped_wr_a: assert property (@(posedge clk) disable iff (rst)
    (wr_stb && !hit) |=> $stable(mask_q) && $stable(ctrl_q) && $stable(last_q))
    else $error("unmapped write changed a register");

endmodule : cfe_top
`default_nettype wire

// [test_capture_field_event_flags.sv]
// Self-checking APB testbench for the capture channel A field event flag block
`timescale 1ns/1ps
`default_nettype none
`include "cfe_params.svh"
module test_capture_field_event_flags;
  import cfe_pkg::*;

  // ----------------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------------
  localparam int LCW = 12;
  logic            clk;
  logic            rst;
  logic            psel;
  logic            penable;
  logic            pwrite;
  logic [11:0]     paddr;
  logic [31:0]     pwdata;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  logic [LCW-1:0]  line_counter;
  logic            line_counter_reset;
  logic            field_is_2;
  logic            vert_event;
  logic            irq;
  logic [31:0]     rd;
  logic            err;
  int              n_errors;
  int              comparisons;
  logic [2:0]      off_modes [3];
  logic [2:0]      std_modes [2];
  logic [31:0]     vexp;

  cfe_top #(.LCW(LCW)) DUT (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_counter(line_counter),
    .line_counter_reset(line_counter_reset), .field_is_2(field_is_2),
    .vert_event(vert_event), .irq(irq)
  );

  // ----------------------------------------------------------------------
  // Clock, reset and watchdog
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Whole run is a few hundred cycles; this bound catches a stuck handshake
  initial begin
    #200000;
    n_errors = n_errors + 1;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rd_chk

  // One cycle of channel timing, then let the flags settle
  task automatic ev(input logic [11:0] cnt, input logic rs, input logic f2, input logic ve);
    @(posedge clk);
    line_counter       <= cnt;
    line_counter_reset <= rs;
    field_is_2         <= f2;
    vert_event         <= ve;
    @(posedge clk);
    line_counter_reset <= 1'b0;
    vert_event         <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : ev

  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    n_errors = 0;
    comparisons = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    line_counter = 12'h000;
    line_counter_reset = 1'b0;
    field_is_2 = 1'b0;
    vert_event = 1'b0;
    off_modes = '{`CFE_MODE_RAW, `CFE_MODE_STREAM, `CFE_MODE_DISP};
    std_modes = '{`CFE_MODE_BT656, `CFE_MODE_YC};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // Reset values, unused bits read zero, unmapped address refused
    rd_chk(`CFE_STATUS_OFS, 32'h0000_0000);
    rd_chk(`CFE_MASK_OFS, 32'h0000_0000);
    rd_chk(`CFE_CTRL_OFS, `CFE_CTRL_RST);
    rd_chk(`CFE_LAST_OFS, `CFE_LAST_RST);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(`CFE_MASK_OFS, 32'hFFFF_FFFF);
    rd_chk(`CFE_MASK_OFS, 32'h0000_00F0);
    wr(`CFE_MASK_OFS, 32'h0000_0000);
    rd_chk(12'h010, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    wr(12'h010, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h0000_0001);
    rd_chk(`CFE_MASK_OFS, 32'h0000_0000);
    wr(`CFE_LAST_OFS, 32'h0000_000A);
    // Raw, transport stream and display: field length flags stay clear
    for (int i = 0; i < 3; i++) begin
      wr(`CFE_CTRL_OFS, {29'h0000_0001, off_modes[i]} | 32'h0000_0030);
      ev(12'h005, 1'b1, 1'b0, 1'b0);
      ev(12'h00B, 1'b0, 1'b0, 1'b1);
      ev(12'h00B, 1'b0, 1'b1, 1'b1);
      vexp = (off_modes[i] == `CFE_MODE_DISP) ? 32'h0000_0030 : 32'h0000_0000;
      rd_chk(`CFE_STATUS_OFS, vexp);
      wr(`CFE_STATUS_OFS, 32'h0000_00F0);
      rd_chk(`CFE_STATUS_OFS, 32'h0000_0000);
    end
    // Standard capture modes
    for (int i = 0; i < 2; i++) begin
      wr(`CFE_CTRL_OFS, {29'h0, std_modes[i]});
      ev(12'h000, 1'b1, 1'b0, 1'b0);
      rd_chk(`CFE_STATUS_OFS, 32'h0000_0000);
      wr(`CFE_CTRL_OFS, {29'h0, std_modes[i]} | 32'h0000_0030);
      ev(12'h00B, 1'b0, 1'b0, 1'b0);
      ev(12'h00B, 1'b1, 1'b0, 1'b0);
      rd_chk(`CFE_STATUS_OFS, 32'h0000_0080);
      wr(`CFE_STATUS_OFS, 32'h0000_0000);
      rd_chk(`CFE_STATUS_OFS, 32'h0000_0080);
      wr(`CFE_STATUS_OFS, 32'h0000_0080);
      ev(12'h005, 1'b1, 1'b0, 1'b0);
      rd_chk(`CFE_STATUS_OFS, 32'h0000_0040);
      wr(`CFE_STATUS_OFS, 32'h0000_0040);
      // Boundary: reset exactly at the last line is neither short nor long
      ev(12'h00A, 1'b1, 1'b0, 1'b0);
      rd_chk(`CFE_STATUS_OFS, 32'h0000_0000);
      ev(12'h00B, 1'b0, 1'b0, 1'b0);
      rd_chk(`CFE_STATUS_OFS, 32'h0000_0080);
      ev(12'h00B, 1'b1, 1'b0, 1'b0);
      wr(`CFE_STATUS_OFS, 32'h0000_0080);
      ev(12'h003, 1'b0, 1'b0, 1'b1);
      rd_chk(`CFE_STATUS_OFS, 32'h0000_0010);
      ev(12'h003, 1'b0, 1'b1, 1'b1);
      rd_chk(`CFE_STATUS_OFS, 32'h0000_0030);
      wr(`CFE_STATUS_OFS, 32'h0000_0010);
      rd_chk(`CFE_STATUS_OFS, 32'h0000_0020);
      wr(`CFE_STATUS_OFS, 32'h0000_0020);
      rd_chk(`CFE_STATUS_OFS, 32'h0000_0000);
    end
    // Reset select 1: every field end counts as long
    wr(`CFE_CTRL_OFS, 32'h0000_0110);
    ev(12'h00A, 1'b1, 1'b0, 1'b0);
    rd_chk(`CFE_STATUS_OFS, 32'h0000_0080);
    wr(`CFE_STATUS_OFS, 32'h0000_0080);
    // Clear lands on the same edge as a new long event: the set wins
    fork
      wr(`CFE_STATUS_OFS, 32'h0000_0080);
      begin
        @(posedge clk);
        ev(12'h00A, 1'b1, 1'b0, 1'b0);
      end
    join
    rd_chk(`CFE_STATUS_OFS, 32'h0000_0080);
    wr(`CFE_STATUS_OFS, 32'h0000_0080);
    wr(`CFE_CTRL_OFS, 32'hFFFF_FFFF);
    rd_chk(`CFE_CTRL_OFS, 32'h0000_0137);
    // Interrupt: raise, mask, unmask, clear
    wr(`CFE_CTRL_OFS, 32'h0000_0000);
    wr(`CFE_MASK_OFS, 32'h0000_0010);
    ev(12'h002, 1'b0, 1'b0, 1'b1);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(`CFE_MASK_OFS, 32'h0000_0020);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(`CFE_MASK_OFS, 32'h0000_0010);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0001);
    wr(`CFE_STATUS_OFS, 32'h0000_0010);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0000_0000);
    tally_and_finish();
  end

endmodule : test_capture_field_event_flags
`default_nettype wire
